//--- core/eam_pkg.sv
// shared constants, types and the slot mapping for the aggregate path
// How it works
// - two cards of four E1 inputs each, eight serial tributaries.
// - each line hunts E1 frame alignment; reports loss, AIS, RAI, violations.
// - AIS sent to network when aggregate lost; RAI requested on local fault.
// - per-line line loopback to network and link loopback into mux.
// - mux takes only active channels from both cards into one stream.
// - each aggregate frame opens with a fixed framing word.
// - slot count per frame follows mode: 8, 4 or 2 channels.
// - demux uses the same slot-to-channel mapping function as the mux.
// - encoder adds rate one half convolutional code bits to mux output.
// - eight-channel mode expands coded bits four times.
// - four-channel mode expands coded bits eight times.
// - encoder always emits two parallel coded streams at the symbol rate.
// - mapper turns each coded bit pair into an I/Q symbol for DQPSK.
package eam_pkg;
    localparam int N_TRIB = 8;
    // documented rates, kbit/s
    localparam int E1_KBPS = 2048;
    localparam int AGG8_KBPS = 16987;
    localparam int AGG4_KBPS = 8494;
    localparam int AGG2_KBPS = 4247;
    localparam int CLK_MHZ = 50;
    localparam int SYM_MHZ = 17;
    localparam logic [5:0] SYM_STEP = 6'(SYM_MHZ);
    localparam logic [5:0] SYM_WRAP = 6'(CLK_MHZ);
    // E1 framing
    localparam logic [6:0] FAS_WORD = 7'h1b;
    localparam logic [8:0] E1_A_POS = 9'h0fb;
    localparam logic [8:0] E1_CNT_LAST = 9'h1ff;
    localparam logic [1:0] LOF_MISSES = 2'h3;
    localparam logic [1:0] AIS_ZEROS = 2'h3;
    // aggregate framing
    localparam logic [7:0] AGG_WORD = 8'hb8;
    localparam logic [7:0] AGG_HDR = 8'h08;
    localparam logic [7:0] AGG_LAST = 8'h87;
    localparam logic [7:0] AGG_HDR_LAST = 8'h07;
    localparam logic [1:0] AGG_MISSES = 2'h2;
    localparam int FIFO_DEPTH = 8;

    typedef enum logic [1:0] {
        EAM_MODE_8 = 2'b00,
        EAM_MODE_4 = 2'b01,
        EAM_MODE_2 = 2'b10
    } eam_mode_t;

    typedef enum logic [0:0] {
        EAM_HUNT = 1'b0,
        EAM_LOCK = 1'b1
    } eam_sync_t;

    // slots per frame minus one, usable as a mask
    function automatic logic [2:0] mode_mask(input logic [1:0] mode);
        case (mode)
            EAM_MODE_4: mode_mask = 3'h3;
            EAM_MODE_2: mode_mask = 3'h1;
            default: mode_mask = 3'h7;
        endcase
    endfunction

    // coded pairs sent per input bit, minus one: expansion factor over two, less one
    function automatic logic [2:0] mode_reps(input logic [1:0] mode);
        case (mode)
            EAM_MODE_4: mode_reps = 3'h3;
            EAM_MODE_2: mode_reps = 3'h7;
            default: mode_reps = 3'h1;
        endcase
    endfunction

    // slot-th active channel: {found, index}
    function automatic logic [3:0] slot_chan(input logic [7:0] act,
                                             input logic [2:0] slot);
        logic [3:0] cnt;
        slot_chan = 4'h0;
        cnt = 4'h0;
        for (int k = 0; k < N_TRIB; k++)
        begin
            if (act[k] && cnt == {1'b0, slot} && !slot_chan[3])
            begin
                slot_chan = {1'b1, 3'(k)};
            end
            cnt = cnt + 4'(act[k]);
        end
    endfunction
endpackage

//--- core/eam_fifo.sv
// small synchronous FIFO with valid/ready on both sides
`timescale 1ns/10ps
module eam_fifo
    import eam_pkg::*;
#(
    parameter int WIDTH = 1,
    parameter int DEPTH = 8
)(
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    input wire logic ce_i,
    input wire logic [WIDTH-1:0] in_data_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    output logic [WIDTH-1:0] out_data_o,
    output logic out_valid_o,
    input wire logic out_ready_i
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
    logic [AW:0] cnt_q, cnt_d;
    logic push, pop;

    always_comb
    begin
        in_ready_o = cnt_q != (AW+1)'(DEPTH);
        out_valid_o = cnt_q != '0;
        out_data_o = mem_q[rd_q];
        push = in_valid_i && in_ready_o;
        pop = out_valid_o && out_ready_i;
        wr_d = push ? AW'((wr_q + 1'b1) % DEPTH) : wr_q;
        rd_d = pop ? AW'((rd_q + 1'b1) % DEPTH) : rd_q;
        cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge clk_sys_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end
        else if (ce_i)
        begin
            wr_q <= wr_d;
            rd_q <= rd_d;
            cnt_q <= cnt_d;
        end
    end

    // storage needs no reset; count guards every read
    always_ff @(posedge clk_sys_i)
    begin
        if (ce_i && push)
        begin
            mem_q[wr_q] <= in_data_i;
        end
    end
endmodule

//--- core/eam_datapath.sv
// E1 framers, aggregate mux/demux, FEC encoder and DQPSK mapper
`timescale 1ns/10ps
module eam_datapath
    import eam_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    input wire logic ce_i,
    input wire logic [7:0] trib_bit_i,
    input wire logic [7:0] trib_stb_i,
    input wire logic [7:0] trib_cv_i,
    input wire logic [7:0] line_lb_i,
    input wire logic [7:0] link_lb_i,
    input wire logic [7:0] chan_act_i,
    input wire logic [1:0] chan_mode_i,
    input wire logic agg_bit_i,
    input wire logic agg_stb_i,
    output logic [7:0] net_bit_o,
    output logic [7:0] net_stb_o,
    output logic [7:0] lof_o,
    output logic [7:0] ais_o,
    output logic [7:0] rai_o,
    output logic [7:0] cv_o,
    output logic [7:0] tx_rai_o,
    output logic dmx_sync_o,
    output logic sym_stb_o,
    output logic coded_a_o,
    output logic coded_b_o,
    output logic i_o,
    output logic q_o
);
    // ---------------- per-line E1 framers ----------------
    logic [6:0] fsh_q [8];
    logic [6:0] fsh_d [8];
    logic [8:0] fcnt_q [8];
    logic [8:0] fcnt_d [8];
    logic [1:0] fmiss_q [8];
    logic [1:0] fmiss_d [8];
    logic [1:0] zcnt_q [8];
    logic [1:0] zcnt_d [8];
    logic [7:0] lof_d, ais_d, rai_d, cv_d;

    always_comb
    begin
        lof_d = lof_o;
        ais_d = ais_o;
        rai_d = rai_o;
        cv_d = trib_cv_i & trib_stb_i;
        for (int i = 0; i < N_TRIB; i++)
        begin
            fsh_d[i] = fsh_q[i];
            fcnt_d[i] = fcnt_q[i];
            fmiss_d[i] = fmiss_q[i];
            zcnt_d[i] = zcnt_q[i];
            if (trib_stb_i[i])
            begin
                fsh_d[i] = {fsh_q[i][5:0], trib_bit_i[i]};
                fcnt_d[i] = fcnt_q[i] + 9'h001;
                if (!trib_bit_i[i] && zcnt_q[i] != AIS_ZEROS)
                begin
                    zcnt_d[i] = zcnt_q[i] + 2'h1;
                end
                if (lof_o[i])
                begin
                    if (fsh_d[i] == FAS_WORD)
                    begin
                        lof_d[i] = 1'b0;
                        fcnt_d[i] = '0;
                        fmiss_d[i] = '0;
                    end
                end
                else if (fcnt_q[i] == E1_CNT_LAST)
                begin
                    if (fsh_d[i] == FAS_WORD)
                    begin
                        fmiss_d[i] = '0;
                    end
                    else if (fmiss_q[i] == LOF_MISSES - 2'h1)
                    begin
                        lof_d[i] = 1'b1;
                        rai_d[i] = 1'b0;
                    end
                    else
                    begin
                        fmiss_d[i] = fmiss_q[i] + 2'h1;
                    end
                end
                else if (fcnt_q[i] == E1_A_POS)
                begin
                    rai_d[i] = trib_bit_i[i];
                end
                // fewer than three zeros in two frames reads as AIS
                if (fcnt_q[i] == E1_CNT_LAST)
                begin
                    ais_d[i] = zcnt_d[i] != AIS_ZEROS;
                    zcnt_d[i] = '0;
                end
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            lof_o <= 8'hff;
            ais_o <= '0;
            rai_o <= '0;
            cv_o <= '0;
            for (int i = 0; i < N_TRIB; i++)
            begin
                fsh_q[i] <= '0;
                fcnt_q[i] <= '0;
                fmiss_q[i] <= '0;
                zcnt_q[i] <= '0;
            end
        end
        else if (ce_i)
        begin
            lof_o <= lof_d;
            ais_o <= ais_d;
            rai_o <= rai_d;
            cv_o <= cv_d;
            for (int i = 0; i < N_TRIB; i++)
            begin
                fsh_q[i] <= fsh_d[i];
                fcnt_q[i] <= fcnt_d[i];
                fmiss_q[i] <= fmiss_d[i];
                zcnt_q[i] <= zcnt_d[i];
            end
        end
    end

    // ---------------- aggregate demux ----------------
    eam_sync_t dsync_q, dsync_d;
    logic [7:0] dsh_q, dsh_d, dpos_q, dpos_d;
    logic [1:0] dmiss_q, dmiss_d;
    logic dflag_q, dflag_d;
    logic [7:0] dbit_q, dbit_d, dstb_q, dstb_d;
    logic [3:0] dsc;

    always_comb
    begin
        dsync_d = dsync_q;
        dsh_d = dsh_q;
        dpos_d = dpos_q;
        dmiss_d = dmiss_q;
        dflag_d = dflag_q;
        dbit_d = dbit_q;
        dstb_d = '0;
        dsc = slot_chan(chan_act_i,
                        3'(dpos_q[7:1]) & mode_mask(chan_mode_i));
        if (agg_stb_i)
        begin
            dsh_d = {dsh_q[6:0], agg_bit_i};
            dpos_d = dpos_q == AGG_LAST ? '0 : dpos_q + 8'h01;
            case (dsync_q)
                EAM_HUNT:
                begin
                    if (dsh_d == AGG_WORD)
                    begin
                        dsync_d = EAM_LOCK;
                        dpos_d = AGG_HDR;
                        dmiss_d = '0;
                    end
                end
                EAM_LOCK:
                begin
                    if (dpos_q == AGG_HDR_LAST)
                    begin
                        if (dsh_d == AGG_WORD)
                        begin
                            dmiss_d = '0;
                        end
                        else if (dmiss_q == AGG_MISSES - 2'h1)
                        begin
                            dsync_d = EAM_HUNT;
                        end
                        else
                        begin
                            dmiss_d = dmiss_q + 2'h1;
                        end
                    end
                    else if (dpos_q >= AGG_HDR)
                    begin
                        if (!dpos_q[0])
                        begin
                            dflag_d = agg_bit_i;
                        end
                        else if (dflag_q && dsc[3])
                        begin
                            dbit_d[dsc[2:0]] = agg_bit_i;
                            dstb_d[dsc[2:0]] = 1'b1;
                        end
                    end
                end
                default:
                    dsync_d = EAM_HUNT;
            endcase
        end
    end

    always_ff @(posedge clk_sys_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            dsync_q <= EAM_HUNT;
            dsh_q <= '0;
            dpos_q <= '0;
            dmiss_q <= '0;
            dflag_q <= 1'b0;
            dbit_q <= '0;
            dstb_q <= '0;
        end
        else if (ce_i)
        begin
            dsync_q <= dsync_d;
            dsh_q <= dsh_d;
            dpos_q <= dpos_d;
            dmiss_q <= dmiss_d;
            dflag_q <= dflag_d;
            dbit_q <= dbit_d;
            dstb_q <= dstb_d;
        end
    end

    // ---------------- network side and alarms out ----------------
    logic [7:0] nbit_d, nstb_d, txrai_d, dead;

    always_comb
    begin
        dead = {8{dsync_q != EAM_LOCK}} | ~chan_act_i;
        for (int i = 0; i < N_TRIB; i++)
        begin
            if (line_lb_i[i])
            begin
                nbit_d[i] = trib_bit_i[i];
                nstb_d[i] = trib_stb_i[i];
            end
            else if (dead[i])
            begin
                // all ones paced by the line's own bit clock
                nbit_d[i] = 1'b1;
                nstb_d[i] = trib_stb_i[i];
            end
            else
            begin
                nbit_d[i] = dbit_q[i];
                nstb_d[i] = dstb_q[i];
            end
        end
        txrai_d = lof_o | ais_o;
    end

    always_ff @(posedge clk_sys_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            net_bit_o <= '0;
            net_stb_o <= '0;
            tx_rai_o <= '0;
            dmx_sync_o <= 1'b0;
        end
        else if (ce_i)
        begin
            net_bit_o <= nbit_d;
            net_stb_o <= nstb_d;
            tx_rai_o <= txrai_d;
            dmx_sync_o <= dsync_d == EAM_LOCK;
        end
    end

    // ---------------- aggregate mux ----------------
    logic [7:0] pend_q, pend_d, pdat_q, pdat_d, src_bit, src_stb;
    logic [7:0] mpos_q, mpos_d;
    logic mflag_q, mflag_d;
    logic mux_bit, mux_ready, fifo_bit, fifo_valid, enc_ready;
    logic [3:0] msc;

    always_comb
    begin
        src_bit = (link_lb_i & dbit_q) | (~link_lb_i & trib_bit_i);
        src_stb = (link_lb_i & dstb_q) | (~link_lb_i & trib_stb_i);
        pend_d = pend_q;
        pdat_d = pdat_q;
        mpos_d = mpos_q;
        mflag_d = mflag_q;
        msc = slot_chan(chan_act_i,
                        3'(mpos_q[7:1]) & mode_mask(chan_mode_i));
        if (mpos_q < AGG_HDR)
        begin
            mux_bit = AGG_WORD[3'(AGG_HDR_LAST - mpos_q)];
        end
        else if (!mpos_q[0])
        begin
            mux_bit = msc[3] && pend_q[msc[2:0]];
        end
        else
        begin
            mux_bit = msc[3] && pdat_q[msc[2:0]];
        end
        if (mux_ready)
        begin
            mpos_d = mpos_q == AGG_LAST ? '0 : mpos_q + 8'h01;
            if (mpos_q >= AGG_HDR && !mpos_q[0])
            begin
                mflag_d = mux_bit;
            end
            if (mpos_q >= AGG_HDR && mpos_q[0] && mflag_q && msc[3])
            begin
                pend_d[msc[2:0]] = 1'b0;
            end
        end
        // a bit arriving as its slot drains stays pending
        for (int i = 0; i < N_TRIB; i++)
        begin
            if (src_stb[i] && chan_act_i[i])
            begin
                pend_d[i] = 1'b1;
                pdat_d[i] = src_bit[i];
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            pend_q <= '0;
            pdat_q <= '0;
            mpos_q <= '0;
            mflag_q <= 1'b0;
        end
        else if (ce_i)
        begin
            pend_q <= pend_d;
            pdat_q <= pdat_d;
            mpos_q <= mpos_d;
            mflag_q <= mflag_d;
        end
    end

    // the encoder drains slower than the mux fills, so the mux stalls here
    eam_fifo #(
        .WIDTH(1),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk_sys_i(clk_sys_i),
        .reset_n_i(reset_n_i),
        .ce_i(ce_i),
        .in_data_i(mux_bit),
        .in_valid_i(1'b1),
        .in_ready_o(mux_ready),
        .out_data_o(fifo_bit),
        .out_valid_o(fifo_valid),
        .out_ready_i(enc_ready)
    );

    // ---------------- FEC encoder and DQPSK mapper ----------------
    logic [5:0] acc_q, acc_d;
    logic [1:0] csr_q, csr_d, phase_q, phase_d;
    logic have_q, have_d, ca_q, ca_d, cb_q, cb_d, tick;
    logic [2:0] rep_q, rep_d;
    logic sa_d, sb_d, ii_d, qq_d;

    always_comb
    begin
        tick = 7'(acc_q) + 7'(SYM_STEP) >= 7'(SYM_WRAP);
        acc_d = tick ? acc_q + SYM_STEP - SYM_WRAP : acc_q + SYM_STEP;
        enc_ready = !have_q;
        have_d = have_q;
        csr_d = csr_q;
        ca_d = ca_q;
        cb_d = cb_q;
        rep_d = rep_q;
        sa_d = coded_a_o;
        sb_d = coded_b_o;
        phase_d = phase_q;
        if (!have_q && fifo_valid)
        begin
            // K=3 code, generators 7 and 5
            ca_d = fifo_bit ^ csr_q[1] ^ csr_q[0];
            cb_d = fifo_bit ^ csr_q[0];
            csr_d = {fifo_bit, csr_q[1]};
            have_d = 1'b1;
            rep_d = '0;
        end
        if (tick)
        begin
            // starved symbols carry 00, which holds the phase
            sa_d = have_q && ca_q;
            sb_d = have_q && cb_q;
            if (have_q)
            begin
                // pair repeats: 2x in 8, 4x in 4, 8x in 2 channel mode
                if (rep_q == mode_reps(chan_mode_i))
                begin
                    have_d = 1'b0;
                end
                else
                begin
                    rep_d = rep_q + 3'h1;
                end
            end
            phase_d = phase_q + {sa_d, sa_d ^ sb_d};
        end
        ii_d = phase_d[1];
        qq_d = phase_d[1] ^ phase_d[0];
    end

    always_ff @(posedge clk_sys_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            acc_q <= '0;
            csr_q <= '0;
            have_q <= 1'b0;
            ca_q <= 1'b0;
            cb_q <= 1'b0;
            rep_q <= '0;
            phase_q <= '0;
            sym_stb_o <= 1'b0;
            coded_a_o <= 1'b0;
            coded_b_o <= 1'b0;
            i_o <= 1'b0;
            q_o <= 1'b0;
        end
        else if (ce_i)
        begin
            acc_q <= acc_d;
            csr_q <= csr_d;
            have_q <= have_d;
            ca_q <= ca_d;
            cb_q <= cb_d;
            rep_q <= rep_d;
            phase_q <= phase_d;
            sym_stb_o <= tick;
            coded_a_o <= sa_d;
            coded_b_o <= sb_d;
            i_o <= ii_d;
            q_o <= qq_d;
        end
    end
endmodule

//--- test/eam_datapath_properties.sv
// port-level properties of the aggregate datapath
`timescale 1ns/10ps
module eam_datapath_properties
    import eam_pkg::*;
(
    input logic clk_sys_i,
    input logic reset_n_i,
    input logic ce_i,
    input logic [7:0] trib_bit_i,
    input logic [7:0] trib_stb_i,
    input logic [7:0] trib_cv_i,
    input logic [7:0] line_lb_i,
    input logic [7:0] net_bit_o,
    input logic [7:0] net_stb_o,
    input logic [7:0] lof_o,
    input logic [7:0] ais_o,
    input logic [7:0] cv_o,
    input logic [7:0] tx_rai_o,
    input logic dmx_sync_o,
    input logic sym_stb_o,
    input logic coded_a_o,
    input logic coded_b_o,
    input logic i_o,
    input logic q_o
);
    default clocking cb @(posedge clk_sys_i);
    endclocking
    // a frozen clock enable would stretch every figure below
    default disable iff (!reset_n_i || !ce_i);
    sequence unlocked_s;
        !dmx_sync_o [*3];
    endsequence
    sequence next_tick_s;
        !sym_stb_o ##[1:2] sym_stb_o;
    endsequence
    cv_pulse_a: assert property ($past(ce_i) |->
        cv_o == $past(trib_cv_i & trib_stb_i))
        else $error("violation pulse wrong");
    lof_clear_a: assert property ($past(ce_i) |->
        ($past(lof_o) & ~lof_o & ~$past(trib_stb_i)) == 8'h00)
        else $error("frame loss cleared without a bit");
    rai_req_a: assert property ($past(ce_i && reset_n_i) |->
        tx_rai_o == $past(lof_o | ais_o))
        else $error("remote alarm request wrong");
    net_ais_a: assert property (unlocked_s |->
        (net_stb_o & ~net_bit_o & ~line_lb_i & ~$past(line_lb_i)) == 8'h00)
        else $error("zero sent while demux unlocked");
    lb_echo_a: assert property ($past(ce_i) |->
        ((net_stb_o ^ $past(trib_stb_i)) & $past(line_lb_i)) == 8'h00 &&
        ((net_bit_o ^ $past(trib_bit_i)) & $past(line_lb_i) & net_stb_o)
        == 8'h00)
        else $error("line loopback echo wrong");
    tick_gap_a: assert property (sym_stb_o |=> next_tick_s)
        else $error("symbol tick spacing wrong");
    sym_hold_a: assert property (!sym_stb_o |->
        $stable({coded_a_o, coded_b_o, i_o, q_o}))
        else $error("symbol outputs moved between ticks");
    phase_step_a: assert property (sym_stb_o |->
        {i_o, i_o ^ q_o} == 2'({$past(i_o), $past(i_o) ^ $past(q_o)} +
        {coded_a_o, coded_a_o ^ coded_b_o}))
        else $error("differential phase step wrong");
endmodule

bind eam_datapath eam_datapath_properties chk_u (
    .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .ce_i(ce_i),
    .trib_bit_i(trib_bit_i), .trib_stb_i(trib_stb_i),
    .trib_cv_i(trib_cv_i), .line_lb_i(line_lb_i),
    .net_bit_o(net_bit_o), .net_stb_o(net_stb_o), .lof_o(lof_o),
    .ais_o(ais_o), .cv_o(cv_o), .tx_rai_o(tx_rai_o),
    .dmx_sync_o(dmx_sync_o), .sym_stb_o(sym_stb_o),
    .coded_a_o(coded_a_o), .coded_b_o(coded_b_o), .i_o(i_o), .q_o(q_o));

//--- test/eam_far_model.sv
// far side model: eight E1 line sources and a remote aggregate source
`timescale 1ns/10ps
module eam_far_model
    import eam_pkg::*;
(
    input logic clk_sys_i,
    input logic reset_n_i,
    input logic [7:0] ais_mask_i,
    input logic [7:0] rai_mask_i,
    input logic [7:0] cv_mask_i,
    output logic [7:0] trib_bit_o,
    output logic [7:0] trib_stb_o,
    output logic [7:0] trib_cv_o,
    output logic agg_bit_o,
    output logic agg_stb_o
);
    logic [1:0] div_q;
    logic [8:0] pos_q;
    logic [7:0] apos_q;
    logic [7:0] last_q;
    logic alast_q;
    logic [7:0] nb;
    logic na;
    always_comb
    begin
        for (int k = 0; k < 8; k++)
        begin
            if (ais_mask_i[k])
                nb[k] = 1'b1;
            else if (pos_q >= 9'h1f9)
                nb[k] = FAS_WORD[3'(9'h1ff - pos_q)];
            else if (pos_q >= 9'h0fa && pos_q <= 9'h0fc)
                nb[k] = rai_mask_i[k]; // spread so an offset still hits
            else
                nb[k] = pos_q[0];
        end
        if (apos_q < 8'h08)
            na = AGG_WORD[3'(8'h07 - apos_q)];
        else
            na = apos_q[0] ? apos_q[1] : 1'b1;
    end
    always_ff @(posedge clk_sys_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            div_q <= 2'h0;
            pos_q <= 9'h000;
            apos_q <= 8'h00;
            last_q <= 8'h00;
            alast_q <= 1'b0;
            trib_bit_o <= 8'h00;
            trib_stb_o <= 8'h00;
            trib_cv_o <= 8'h00;
            agg_bit_o <= 1'b0;
            agg_stb_o <= 1'b0;
        end
        else
        begin
            div_q <= div_q + 2'h1;
            trib_stb_o <= {8{div_q == 2'h3}};
            trib_cv_o <= div_q == 2'h3 ? cv_mask_i : 8'h00;
            agg_stb_o <= div_q[0];
            if (div_q == 2'h3)
            begin
                pos_q <= pos_q + 9'h001;
                last_q <= nb;
            end
            // between strobes the lines show junk, not the held bit
            trib_bit_o <= div_q == 2'h3 ? nb : ~last_q;
            if (div_q[0])
            begin
                apos_q <= apos_q == AGG_LAST ? 8'h00 : apos_q + 8'h01;
                alast_q <= na;
            end
            agg_bit_o <= div_q[0] ? na : ~alast_q;
        end
    end
endmodule

//--- test/tb.sv
// self-checking bench for the aggregate datapath
`timescale 1ns/10ps
module tb;
    import eam_pkg::*;
    logic clk_sys_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic [7:0] trib_bit, trib_stb, trib_cv, net_bit_o, net_stb_o;
    logic [7:0] lof_o, ais_o, rai_o, cv_o, tx_rai_o;
    logic [7:0] line_lb = 8'h00;
    logic [7:0] chan_act = 8'hff;
    logic [1:0] chan_mode = 2'h0;
    logic [7:0] ais_mask = 8'h00;
    logic [7:0] cv_mask = 8'h00;
    logic agg_bit, agg_stb, dmx_sync_o, sym_stb_o;
    logic coded_a_o, coded_b_o, i_o, q_o;
    int err_total = 0;
    int samples_checked = 0;
    always #10 clk_sys_i = ~clk_sys_i;
    eam_far_model far_u (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
        .ais_mask_i(ais_mask), .rai_mask_i(8'ha5), .cv_mask_i(cv_mask),
        .trib_bit_o(trib_bit), .trib_stb_o(trib_stb), .trib_cv_o(trib_cv),
        .agg_bit_o(agg_bit), .agg_stb_o(agg_stb));
    eam_datapath dut_u (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
        .ce_i(1'b1), .trib_bit_i(trib_bit), .trib_stb_i(trib_stb),
        .trib_cv_i(trib_cv), .line_lb_i(line_lb), .link_lb_i(8'h00),
        .chan_act_i(chan_act), .chan_mode_i(chan_mode),
        .agg_bit_i(agg_bit), .agg_stb_i(agg_stb), .net_bit_o(net_bit_o),
        .net_stb_o(net_stb_o), .lof_o(lof_o), .ais_o(ais_o),
        .rai_o(rai_o), .cv_o(cv_o), .tx_rai_o(tx_rai_o),
        .dmx_sync_o(dmx_sync_o), .sym_stb_o(sym_stb_o),
        .coded_a_o(coded_a_o), .coded_b_o(coded_b_o), .i_o(i_o), .q_o(q_o));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            err_total++;
            $display("[FAIL] %0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict();
        if (err_total == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk_sys_i);
        #1;
    endtask
    task automatic wait_for(input int sel, input logic [7:0] want);
        logic [7:0] v;
        for (int n = 0; n < 12000; n++)
        begin
            v = sel == 0 ? lof_o : sel == 1 ? ais_o : 8'(dmx_sync_o);
            if (v === want)
                return;
            step(1);
        end
        err_total++;
        $display("[FAIL] %0t wait expired", $time);
        print_verdict();
    endtask
    task automatic t_frame();
        logic [7:0] acc;
        wait_for(0, 8'h00);
        step(2);
        check(tx_rai_o, 8'h00);
        check(ais_o, 8'h00);
        step(2100);
        check(rai_o, 8'ha5);
        cv_mask = 8'h3c;
        acc = 8'h00;
        repeat (12)
        begin
            step(1);
            acc = acc | cv_o;
        end
        cv_mask = 8'h00;
        check(acc, 8'h3c);
    endtask
    task automatic t_loop();
        int c;
        line_lb = 8'h0f;
        step(2);
        c = 0;
        repeat (40)
        begin
            step(1);
            c += net_stb_o[0];
        end
        line_lb = 8'h00;
        check(8'(c), 8'h0a);
    endtask
    task automatic t_rate();
        int n;
        n = 0;
        repeat (500)
        begin
            step(1);
            n += sym_stb_o;
        end
        check(8'(n), 8'(SYM_MHZ * 10));
    endtask
    task automatic t_demux(input logic [7:0] act, input logic [7:0] ones,
                           input logic [7:0] zeros);
        logic [7:0] s1;
        logic [7:0] s0;
        chan_act = act;
        wait_for(2, 8'h01);
        step(300);
        s1 = 8'h00;
        s0 = 8'h00;
        repeat (600)
        begin
            step(1);
            s1 = s1 | (net_stb_o & net_bit_o);
            s0 = s0 | (net_stb_o & ~net_bit_o);
        end
        check(s1, ones);
        check(s0, zeros);
    endtask
    task automatic t_ais();
        ais_mask = 8'hf0;
        wait_for(1, 8'hf0);
        wait_for(0, 8'hf0);
        step(2);
        check(tx_rai_o, 8'hf0);
        ais_mask = 8'h00;
    endtask
    task automatic t_modes();
        int t;
        int last;
        int bad;
        int chg;
        logic [1:0] pr;
        for (int m = 0; m < 3; m++)
        begin
            chan_mode = 2'(m);
            step(300);
            t = 0;
            last = -1;
            bad = 0;
            chg = 0;
            pr = {coded_a_o, coded_b_o};
            repeat (1500)
            begin
                step(1);
                if (sym_stb_o === 1'b1)
                begin
                    t++;
                    if ({coded_a_o, coded_b_o} !== pr)
                    begin
                        // a coded pair may only change on a group edge
                        if (last >= 0 && (t - last) % (2 << m) != 0)
                            bad++;
                        last = t;
                        chg++;
                        pr = {coded_a_o, coded_b_o};
                    end
                end
            end
            check(8'(bad), 8'h00);
            check(8'(chg > 2), 8'h01);
        end
        chan_mode = 2'h0;
    endtask
    initial
    begin
        step(19);
        check(lof_o, 8'hff);
        check(ais_o | tx_rai_o | cv_o, 8'h00);
        check({5'h00, sym_stb_o, i_o, q_o}, 8'h00);
        step(1);
        reset_n_i = 1'b1;
        t_frame();
        t_loop();
        t_rate();
        t_demux(8'hff, 8'haa, 8'h55);
        t_demux(8'h0f, 8'hfa, 8'h05);
        t_ais();
        t_modes();
        print_verdict();
    end
endmodule
